// ---- verilog/interrupt_vector_placement.sv ----
// vector address generation and vector table relocation
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - 21 vectors, vector N at 2*(N-1)
// - every reset source restarts at reset vector
// - boot reset fuse moves reset entry
// - select clear keeps vectors at 0x0002
// - boot start from size fuses, 1=unprogrammed
// - 2K boot size gives 0x1C00 and 0x1C02
// - select changes only while unlock set
// - unlock clears after four cycles or select
// - interrupts blocked through unlock and next instruction
// - unused unlock blocks four cycles then resumes
// - global enable flag left untouched
// - boot vectors, app lock: block in app
// - app vectors, boot lock: block in boot
module interrupt_vector_placement (
  input  wire logic                            sys_clk_i,
  input  wire logic                            nrst_i,
  input  wire logic [ivp_pkg::AV_ADDR_W-1:0]   avs_address_i,
  input  wire logic                            avs_read_i,
  input  wire logic                            avs_write_i,
  input  wire logic [31:0]                     avs_writedata_i,
  input  wire logic [3:0]                      avs_byteenable_i,
  output logic      [31:0]                     avs_readdata_o,
  output logic                                 avs_waitrequest_o,
  output logic                                 irq_o,
  input  wire logic [ivp_pkg::SRC_W-1:0]       rst_src_i,
  input  wire logic                            boot_reset_fuse_i,
  input  wire logic [1:0]                      boot_size_fuses_i,
  input  wire logic                            app_section_lock_bit_i,
  input  wire logic                            boot_section_lock_bit_i,
  input  wire logic [ivp_pkg::IRQ_NUM-1:0]     irq_req_i,
  input  wire logic                            global_ie_i,
  input  wire logic [ivp_pkg::ADDR_W-1:0]      pc_i,
  input  wire logic                            instr_done_i,
  output logic      [ivp_pkg::ADDR_W-1:0]      reset_addr_o,
  output logic                                 restart_o,
  output logic                                 irq_take_o,
  output logic      [ivp_pkg::NUM_W-1:0]       irq_vec_num_o,
  output logic      [ivp_pkg::ADDR_W-1:0]      irq_addr_o
);
  import ivp_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // boot section start from size fuses
  function automatic logic [ADDR_W-1:0] boot_start(input logic [1:0] sz);
    logic [ADDR_W-1:0] r;
    r = BOOT_START_512;
    unique case (sz)
      SZ_4K:  r = BOOT_START_4K;
      SZ_2K:  r = BOOT_START_2K;
      SZ_1K:  r = BOOT_START_1K;
      SZ_512: r = BOOT_START_512;
    endcase
    return r;
  endfunction
  // vector N sits two words per step above the base
  function automatic logic [ADDR_W-1:0] vec_addr(input logic [NUM_W-1:0] num,
                                                 input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] off;
    off = ADDR_W'({num - NUM_ONE, 1'b0});
    return base + off;
  endfunction
  // lowest set request index
  function automatic logic [NUM_W-1:0] first_set(input logic [IRQ_NUM-1:0] p);
    logic [NUM_W-1:0] r;
    r = '0;
    for (int i = IRQ_NUM - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = NUM_W'(i);
      end
    end
    return r;
  endfunction
  logic [PIN_W-1:0]  meta_q;
  logic [PIN_W-1:0]  pin_q;
  logic [SRC_W-1:0]  src_s;
  logic              rst_fuse_s;
  logic [1:0]        sz_s;
  logic              app_lk_s;
  logic              boot_lk_s;
  // two-stage synchronisers for pins
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= PIN_RST;
      pin_q  <= PIN_RST;
    end else begin
      meta_q <= {rst_src_i, boot_section_lock_bit_i, app_section_lock_bit_i,
                 boot_size_fuses_i, boot_reset_fuse_i};
      pin_q  <= meta_q;
    end
  end
  assign src_s      = pin_q[PIN_W-1 -: SRC_W];
  assign boot_lk_s  = pin_q[4];
  assign app_lk_s   = pin_q[3];
  assign sz_s       = pin_q[2:1];
  assign rst_fuse_s = pin_q[0];
  // ---- bus slave ----
  logic              wait_q, wait_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [IDX_W-1:0]  idx;
  logic              acc_wr;
  logic              ctrl_wr;
  logic [31:0]       rd_val;
  logic              sel_q, sel_d;
  logic              unl_q, unl_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              post_q, post_d;
  logic [EN_W-1:0]   en_q, en_d;
  logic [EV_W-1:0]   stat_q, stat_d;
  logic [EV_W-1:0]   mask_q, mask_d;
  logic [EV_W-1:0]   ev;
  logic              irq_q;
  logic [ADDR_W-1:0] bs;
  logic [ADDR_W-1:0] rst_addr_q, rst_addr_d;
  assign idx     = avs_address_i[AV_ADDR_W-1:2];
  assign acc_wr  = avs_write_i & !wait_q & avs_byteenable_i[0];
  assign ctrl_wr = acc_wr & (idx == IDX_CTRL);
  // register read mux, unmapped reads zero
  always_comb begin
    rd_val = '0;
    unique case (idx)
      IDX_CTRL: begin
        rd_val[CB_EN1]    = en_q[2];
        rd_val[CB_EN0]    = en_q[1];
        rd_val[CB_EN2]    = en_q[0];
        rd_val[CB_SEL]    = sel_q;
        rd_val[CB_UNLOCK] = unl_q;
      end
      IDX_STAT: rd_val[EV_W-1:0] = stat_q;
      IDX_MASK: rd_val[EV_W-1:0] = mask_q;
      IDX_INFO: begin
        rd_val[INFO_RST_LSB +: ADDR_W] = rst_addr_q;
        rd_val[ADDR_W-1:0] = sel_q ? bs : RESET_VEC;
      end
      default: rd_val = '0;
    endcase
  end
  // one wait state per access, read data ready at acceptance
  always_comb begin
    wait_d  = !((avs_read_i | avs_write_i) & wait_q);
    rdata_d = rdata_q;
    if (avs_read_i && wait_q) begin
      rdata_d = rd_val;
    end
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end
  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;
  // ---- control register and unlock window ----
  always_comb begin
    sel_d  = sel_q;
    unl_d  = unl_q;
    cnt_d  = cnt_q;
    post_d = post_q;
    en_d   = en_q;
    ev     = '0;
    if (unl_q) begin
      cnt_d = cnt_q - CNT_LAST;
      if (cnt_q == CNT_LAST) begin
        unl_d = 1'b0;
        ev[EV_TIMEOUT] = !ctrl_wr;
      end
    end
    if (post_q && instr_done_i) begin
      post_d = 1'b0;
    end
    if (ctrl_wr) begin
      en_d = {avs_writedata_i[CB_EN1], avs_writedata_i[CB_EN0],
              avs_writedata_i[CB_EN2]};
      if (avs_writedata_i[CB_UNLOCK]) begin
        unl_d = 1'b1;
        cnt_d = UNLOCK_CYC;
      end else if (unl_q) begin
        sel_d  = avs_writedata_i[CB_SEL];
        unl_d  = 1'b0;
        cnt_d  = '0;
        post_d = 1'b1;
        ev[EV_MOVED] = sel_d != sel_q;
      end
    end
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_q  <= 1'b0;
      unl_q  <= 1'b0;
      cnt_q  <= '0;
      post_q <= 1'b0;
      en_q   <= EN_RST;
    end else begin
      sel_q  <= sel_d;
      unl_q  <= unl_d;
      cnt_q  <= cnt_d;
      post_q <= post_d;
      en_q   <= en_d;
    end
  end
  a_unlock_expiry: assert property (
    $rose(unl_q) ##0 (!ctrl_wr)[*4] |=> !unl_q)
    else $error("unlock bit did not expire after four cycles");
  a_sel_guarded: assert property (
    ctrl_wr && !unl_q |=> sel_q == $past(sel_q))
    else $error("select changed without unlock");
  a_sel_write: assert property (
    ctrl_wr && unl_q && !avs_writedata_i[CB_UNLOCK]
    |=> !unl_q && sel_q == $past(avs_writedata_i[CB_SEL]))
    else $error("select write did not take or unlock stayed");
  // ---- event status, mask and interrupt line ----
  logic [EV_W-1:0] w1c;
  logic            src_any_q, boot_q;
  logic            restart_q, restart_d;
  always_comb begin
    w1c    = (acc_wr && idx == IDX_STAT) ? avs_writedata_i[EV_W-1:0] : '0;
    stat_d = (stat_q & ~w1c) | ev; // set wins over clear
    stat_d[EV_RESTART] = stat_d[EV_RESTART] | restart_d;
    mask_d = (acc_wr && idx == IDX_MASK) ? avs_writedata_i[EV_W-1:0] : mask_q;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_q <= EV_RST;
      mask_q <= EV_RST;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= |(stat_d & mask_d);
    end
  end
  assign irq_o = irq_q;
  // ---- reset entry and restart ----
  assign bs = boot_start(sz_s);

  always_comb begin
    rst_addr_d = rst_fuse_s ? RESET_VEC : bs;
    restart_d  = boot_q | (src_any_q & ~|src_s);
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_addr_q <= RESET_VEC;
      src_any_q  <= 1'b0;
      boot_q     <= 1'b1;
      restart_q  <= 1'b0;
    end else begin
      rst_addr_q <= rst_addr_d;
      src_any_q  <= |src_s;
      boot_q     <= 1'b0;
      restart_q  <= restart_d;
    end
  end
  assign reset_addr_o = rst_addr_q;
  assign restart_o    = restart_q;

  a_restart_src: assert property (
    $fell(src_any_q) |-> restart_o)
    else $error("no restart after reset source released");
  a_boot_reset: assert property (
    !rst_fuse_s && sz_s == SZ_2K |=> reset_addr_o == BOOT_START_2K)
    else $error("boot reset address wrong for 2K section");

  // ---- dispatch ----
  logic [IRQ_NUM-1:0] pend;
  logic               in_app, lock_blk, blk, may_take;
  logic [NUM_W-1:0]   num_d;
  logic               take_q;
  logic [NUM_W-1:0]   num_q;
  logic [ADDR_W-1:0]  addr_q, addr_d;

  // blocking never touches the core's global enable flag
  always_comb begin
    pend = irq_req_i;
    pend[IRQ_EXT0] = irq_req_i[IRQ_EXT0] & en_q[1];
    pend[IRQ_EXT1] = irq_req_i[IRQ_EXT1] & en_q[2];
    pend[IRQ_EXT2] = irq_req_i[IRQ_EXT2] & en_q[0];
    in_app   = pc_i < bs;
    lock_blk = (sel_q & app_lk_s & in_app)
             | (!sel_q & boot_lk_s & !in_app);
    blk      = unl_q | post_q | lock_blk
             | (ctrl_wr & avs_writedata_i[CB_UNLOCK]);
    may_take = global_ie_i & !blk & (|pend);
    num_d    = first_set(pend) + FIRST_IRQ_NUM;
    addr_d   = vec_addr(num_d, sel_q ? bs : RESET_VEC);
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      take_q <= 1'b0;
      num_q  <= '0;
      addr_q <= RESET_VEC;
    end else begin
      take_q <= may_take;
      num_q  <= num_d;
      addr_q <= addr_d;
    end
  end
  assign irq_take_o    = take_q;
  assign irq_vec_num_o = num_q;
  assign irq_addr_o    = addr_q;

  a_block_unlock: assert property (
    unl_q || post_q |=> !irq_take_o)
    else $error("interrupt taken during unlock sequence");
  a_resume_take: assert property (
    !unl_q && !post_q && !lock_blk && !ctrl_wr && global_ie_i && (|pend)
    |=> irq_take_o)
    else $error("interrupt not resumed after unlock window");
  a_lock_app: assert property (
    sel_q && app_lk_s && pc_i < bs |=> !irq_take_o)
    else $error("interrupt taken in locked application section");
  a_lock_boot: assert property (
    !sel_q && boot_lk_s && pc_i >= bs |=> !irq_take_o)
    else $error("interrupt taken in locked boot section");
  a_vec_place: assert property (
    irq_take_o |-> irq_addr_o == vec_addr(irq_vec_num_o,
                                          $past(sel_q) ? $past(bs) : RESET_VEC))
    else $error("vector address does not match number and base");
  a_lowest_first: assert property (
    irq_take_o |-> ($past(pend) & ((IRQ_NUM'(1) << (irq_vec_num_o - NUM_ONE)) - IRQ_NUM'(1)))
                   == (IRQ_NUM'(1) << (irq_vec_num_o - FIRST_IRQ_NUM)))
    else $error("lower vector pending but higher dispatched");
  a_app_base: assert property (
    irq_take_o && !$past(sel_q) && irq_vec_num_o == FIRST_IRQ_NUM
    |-> irq_addr_o == vec_addr(FIRST_IRQ_NUM, RESET_VEC))
    else $error("first vector not at application base");
endmodule

// ---- common/ivp_pkg.sv ----
// constants for vector placement and relocation logic
package ivp_pkg;
  localparam int ADDR_W = 13;               // program word address width
  localparam int IRQ_NUM = 20;              // interrupt vectors 2..21
  localparam int NUM_W = 5;                 // vector number width
  localparam logic [NUM_W-1:0] FIRST_IRQ_NUM = 5'h02;
  localparam logic [NUM_W-1:0] NUM_ONE = 5'h01;
  localparam logic [ADDR_W-1:0] RESET_VEC = 13'h0000;
  // boot section start per boot size fuse code
  localparam logic [1:0] SZ_4K = 2'h0;
  localparam logic [1:0] SZ_2K = 2'h1;
  localparam logic [1:0] SZ_1K = 2'h2;
  localparam logic [1:0] SZ_512 = 2'h3;
  localparam logic [ADDR_W-1:0] BOOT_START_4K = 13'h1800;
  localparam logic [ADDR_W-1:0] BOOT_START_2K = 13'h1C00;
  localparam logic [ADDR_W-1:0] BOOT_START_1K = 13'h1E00;
  localparam logic [ADDR_W-1:0] BOOT_START_512 = 13'h1F00;
  // unlock window
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] UNLOCK_CYC = 3'h4;
  localparam logic [CNT_W-1:0] CNT_LAST = 3'h1;
  // register indices, byte address is index times four
  localparam int AV_ADDR_W = 5;
  localparam int IDX_W = 3;
  localparam logic [IDX_W-1:0] IDX_CTRL = 3'h0;
  localparam logic [IDX_W-1:0] IDX_STAT = 3'h1;
  localparam logic [IDX_W-1:0] IDX_MASK = 3'h2;
  localparam logic [IDX_W-1:0] IDX_INFO = 3'h3;
  // control register bits
  localparam int CB_UNLOCK = 0;
  localparam int CB_SEL = 1;
  localparam int CB_EN2 = 5;
  localparam int CB_EN0 = 6;
  localparam int CB_EN1 = 7;
  localparam int EN_W = 3;
  localparam logic [EN_W-1:0] EN_RST = 3'h0;
  // irq request positions of the external sources
  localparam int IRQ_EXT0 = 0;
  localparam int IRQ_EXT1 = 1;
  localparam int IRQ_EXT2 = 17;
  // event status bits
  localparam int EV_W = 3;
  localparam int EV_TIMEOUT = 0;
  localparam int EV_MOVED = 1;
  localparam int EV_RESTART = 2;
  localparam logic [EV_W-1:0] EV_RST = 3'h0;
  localparam int INFO_RST_LSB = 16;
  // synchronised pins: reset sources and fuse bits
  localparam int SRC_W = 5;
  localparam int PIN_W = 10;
  localparam logic [PIN_W-1:0] PIN_RST = 10'h01F;
endpackage

// ---- tb/core_model.sv ----
// processor core stand-in: retires instructions, fetches vectors
`timescale 1ns/1ps
module core_model (
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ie_i,
  input  wire logic        irq_take_i,
  input  wire logic [12:0] irq_addr_i,
  output logic             global_ie_o,
  output logic             instr_done_o,
  output logic [12:0]      fetch_addr_o
);
  logic [1:0] cyc_q;
  // one instruction every fourth cycle, vector latched on dispatch
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cyc_q        <= 2'h0;
      instr_done_o <= 1'b0;
      fetch_addr_o <= 13'h0000;
    end else begin
      cyc_q        <= cyc_q + 2'h1;
      instr_done_o <= (cyc_q == 2'h3);
      if (irq_take_i) fetch_addr_o <= irq_addr_i;
    end
  end
  // enable flag owned by the core only
  assign global_ie_o = ie_i;
endmodule

// ---- tb/interrupt_vector_placement_tb.sv ----
// self-checking bench for vector placement and relocation
`timescale 1ns/1ps
module interrupt_vector_placement_tb;
  import ivp_pkg::*;
  logic        clk, nrst, rd, wr, wreq, irq, brf, alk, blk, ie, gie, done, rs, take;
  logic [4:0]  adr, src, num;
  logic [31:0] wd, rdat, q;
  logic [3:0]  be;
  logic [1:0]  bsz;
  logic [19:0] req;
  logic [12:0] pc, radr, vadr, fetch;
  int          errors, total_checks, cycles, n;
  logic [12:0] bs [4] = '{BOOT_START_4K, BOOT_START_2K, BOOT_START_1K, BOOT_START_512};

  interrupt_vector_placement u_interrupt_vector_placement (
    .sys_clk_i(clk), .nrst_i(nrst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .irq_o(irq),
    .rst_src_i(src), .boot_reset_fuse_i(brf), .boot_size_fuses_i(bsz),
    .app_section_lock_bit_i(alk), .boot_section_lock_bit_i(blk), .irq_req_i(req),
    .global_ie_i(gie), .pc_i(pc), .instr_done_i(done), .reset_addr_o(radr),
    .restart_o(rs), .irq_take_o(take), .irq_vec_num_o(num), .irq_addr_o(vadr));
  core_model u_core_model (
    .sys_clk_i(clk), .nrst_i(nrst), .ie_i(ie), .irq_take_i(take),
    .irq_addr_i(vadr), .global_ie_o(gie), .instr_done_o(done), .fetch_addr_o(fetch));

  // clock and cycle ceiling
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    rd  <= !w;
    wr  <= w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdv(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic t_regs;
    rdv(5'h00, 32'h0);
    rdv(5'h08, 32'h0);
    bus(1'b1, 5'h10, 32'hFF);
    rdv(5'h10, 32'h0);
    bus(1'b1, 5'h04, 32'h07);
    $display("regs done");
  endtask
  task automatic t_table;
    bus(1'b1, 5'h00, 32'hE0);
    for (int i = 0; i < 20; i++) begin
      req <= 20'h1 << i;
      wt(3);
      chk(take, 1);
      chk(num, i + 2);
      chk(vadr, 2 * (i + 1));
    end
    req <= 20'hFFFFF;
    wt(3);
    chk(num, 2);
    req <= 20'h1;
    $display("table done");
  endtask
  task automatic t_raddr;
    brf <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      bsz <= s[1:0];
      wt(8);
      chk(radr, bs[s]);
    end
    chk(vadr, 13'h0002);
    brf <= 1'b1;
    bsz <= 2'h1;
    wt(8);
    chk(radr, 0);
    $display("reset address done");
  endtask
  task automatic t_restart;
    for (int i = 0; i < 5; i++) begin
      src <= 5'h1 << i;
      wt(2);
      src <= 5'h0;
      n = 0;
      repeat (12) begin
        @(posedge clk);
        n += rs;
      end
      chk(n, 1);
    end
    bus(1'b1, 5'h04, 32'h07);
    $display("restart done");
  endtask
  task automatic t_expire;
    bus(1'b1, 5'h00, 32'hE1);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      chk(take, 0);
    end
    @(posedge clk);
    chk(take, 1);
    ie <= 1'b0;
    wt(3);
    chk(take, 0);
    ie <= 1'b1;
    rdv(5'h00, 32'hE0);
    rdv(5'h04, 32'h1);
    chk(irq, 0);
    bus(1'b1, 5'h08, 32'h1);
    wt(2);
    chk(irq, 1);
    bus(1'b1, 5'h04, 32'h1);
    wt(2);
    chk(irq, 0);
    $display("expire done");
  endtask
  task automatic t_lock(input logic sel);
    alk <= sel;
    blk <= !sel;
    pc  <= sel ? 13'h0100 : 13'h1C10;
    wt(4);
    chk(take, 0);
    pc <= sel ? 13'h1C10 : 13'h0100;
    wt(4);
    chk(take, 1);
    alk <= 1'b0;
    blk <= 1'b0;
    $display("lock done");
  endtask
  task automatic t_move;
    bus(1'b1, 5'h00, 32'hE2);
    rdv(5'h00, 32'hE0);
    bus(1'b1, 5'h00, 32'hE1);
    bus(1'b1, 5'h00, 32'hE2);
    rdv(5'h00, 32'hE2);
    rdv(5'h04, 32'h2);
    rdv(5'h0C, 32'h00001C00);
    wt(8);
    chk(vadr, BOOT_START_2K + 13'h0002);
    chk(fetch, 13'h1C02);
    $display("move done");
  endtask

  initial begin
    nrst = 1'b0;
    {rd, wr, brf, alk, blk, ie} = 6'b001001;
    adr = 5'h00;
    wd  = 32'h0;
    be  = 4'hF;
    src = 5'h00;
    bsz = 2'h1;
    req = 20'h0;
    pc  = 13'h0100;
    wt(3);
    nrst <= 1'b1;
    t_regs();
    t_table();
    t_raddr();
    t_restart();
    t_expire();
    t_lock(1'b0);
    t_move();
    t_lock(1'b1);
    results();
  end
endmodule
